// >>> hw/ram_pkg.sv
// shared constants for the dual-port synchronous memory
package ram_pkg;
  localparam int          WORD_W     = 18;
  localparam int          LANE_SPLIT = 9;
  localparam int          ADDR_WIDTH = 13;
  localparam int          PORTS      = 2;
  localparam logic        SEL_ON     = 1'b1;
  localparam logic        SEL_OFF    = 1'b0;
  localparam logic [1:0]  LANES_OFF  = 2'h3;
  localparam logic [1:0]  LANES_ON   = 2'h0;
  localparam int          UPPER      = 1;
  localparam int          LOWER      = 0;
  localparam int          ONE_STAGE  = 1;
  localparam int          TWO_STAGE  = 2;
endpackage

// >>> hw/address_counter.sv
// internal address register with load, advance, hold and clear
`timescale 1ns/1ps
module address_counter
  import ram_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] ext_addr,
  input  wire logic              address_load_strobe_n,
  input  wire logic              counter_advance_n,
  input  wire logic              counter_clear_n,
  output logic      [ADDR_W-1:0] addr
);
  logic [ADDR_W-1:0] next_addr;

  // clear beats load, load beats advance; chip and byte selects never enter
  always_comb begin
    if (!counter_clear_n) begin
      next_addr = '0;
    end else if (!address_load_strobe_n) begin
      next_addr = ext_addr;
    end else if (!counter_advance_n) begin
      next_addr = addr + ADDR_W'(1);
    end else begin
      next_addr = addr;
    end
  end

  // no documented start value; zero keeps simulation defined
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      addr <= '0;
    end else begin
      addr <= next_addr;
    end
  end
endmodule

// >>> hw/dual_port_ram.sv
// true dual-port synchronous memory with two independent ports
//
// What this block does
// - one shared 18-bit array, 8K or 4K deep, both ports concurrent.
// - each port registers address, data and controls on its rising edge.
// - output gate high floats both lanes at once, unclocked.
// - chip select inactive at an edge deselects the port, lanes float.
// - chip select takes one stage flow-through, two stages pipelined.
// - byte selects always pass one register stage.
// - selected write stores each lane whose byte select is low.
// - selected read with gate low drives only lanes with byte select low.
// - load strobe low, clear high loads external address for the access.
// - load and clear act regardless of chip and byte selects.
// - advance low, strobe and clear high uses previous address plus one.
// - strobe, advance and clear high reuse the current internal address.
// - clear low sets address zero, over load and advance.
// - pipelined mode delivers read data one cycle later than flow-through.
// - each port picks its own latency with its latency-select input.
// - writes complete inside the cycle, adding no clock cycles.
// - strobe held low loads a fresh external address on every edge.
`timescale 1ns/1ps
module dual_port_ram
  import ram_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH,
  parameter int USED_W = ADDR_WIDTH
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] a_addr,
  input  wire logic              a_address_load_strobe_n,
  input  wire logic              a_counter_advance_n,
  input  wire logic              a_counter_clear_n,
  input  wire logic              a_chip_select_n,
  input  wire logic              a_chip_select_active_high,
  input  wire logic              a_upper_byte_select_n,
  input  wire logic              a_lower_byte_select_n,
  input  wire logic              a_read_not_write,
  input  wire logic              a_output_gate_n,
  input  wire logic              a_output_latency_select,
  input  wire logic [WORD_W-1:0] a_dq_in,
  output logic      [WORD_W-1:0] a_dq_out,
  output logic      [1:0]        a_dq_oe_n,
  output logic                   a_standby,
  input  wire logic [ADDR_W-1:0] b_addr,
  input  wire logic              b_address_load_strobe_n,
  input  wire logic              b_counter_advance_n,
  input  wire logic              b_counter_clear_n,
  input  wire logic              b_chip_select_n,
  input  wire logic              b_chip_select_active_high,
  input  wire logic              b_upper_byte_select_n,
  input  wire logic              b_lower_byte_select_n,
  input  wire logic              b_read_not_write,
  input  wire logic              b_output_gate_n,
  input  wire logic              b_output_latency_select,
  input  wire logic [WORD_W-1:0] b_dq_in,
  output logic      [WORD_W-1:0] b_dq_out,
  output logic      [1:0]        b_dq_oe_n,
  output logic                   b_standby
);
  localparam int DEPTH = 2 ** ADDR_W;

  // drops address bits the variant does not have
  function automatic logic [ADDR_W-1:0] word_index(
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] mask;
    mask = '0;
    for (int i = 0; i < USED_W; i++) begin
      mask[i] = 1'b1;
    end
    return a & mask;
  endfunction

  // per-port views of the pins, index 0 is port a
  logic [ADDR_W-1:0] ext_addr   [PORTS];
  logic              load_n     [PORTS];
  logic              adv_n      [PORTS];
  logic              clr_n      [PORTS];
  logic              cs_n       [PORTS];
  logic              cs_hi      [PORTS];
  logic              ub_n       [PORTS];
  logic              lb_n       [PORTS];
  logic              rd         [PORTS];
  logic              gate_n     [PORTS];
  logic              lat_pin    [PORTS];
  logic [WORD_W-1:0] din        [PORTS];
  logic [WORD_W-1:0] dout       [PORTS];
  logic [1:0]        lane_off   [PORTS];
  logic              stby       [PORTS];

  assign ext_addr[0] = a_addr;
  assign load_n[0]   = a_address_load_strobe_n;
  assign adv_n[0]    = a_counter_advance_n;
  assign clr_n[0]    = a_counter_clear_n;
  assign cs_n[0]     = a_chip_select_n;
  assign cs_hi[0]    = a_chip_select_active_high;
  assign ub_n[0]     = a_upper_byte_select_n;
  assign lb_n[0]     = a_lower_byte_select_n;
  assign rd[0]       = a_read_not_write;
  assign gate_n[0]   = a_output_gate_n;
  assign lat_pin[0]  = a_output_latency_select;
  assign din[0]      = a_dq_in;
  assign ext_addr[1] = b_addr;
  assign load_n[1]   = b_address_load_strobe_n;
  assign adv_n[1]    = b_counter_advance_n;
  assign clr_n[1]    = b_counter_clear_n;
  assign cs_n[1]     = b_chip_select_n;
  assign cs_hi[1]    = b_chip_select_active_high;
  assign ub_n[1]     = b_upper_byte_select_n;
  assign lb_n[1]     = b_lower_byte_select_n;
  assign rd[1]       = b_read_not_write;
  assign gate_n[1]   = b_output_gate_n;
  assign lat_pin[1]  = b_output_latency_select;
  assign din[1]      = b_dq_in;

  assign a_dq_out  = dout[0];
  assign b_dq_out  = dout[1];
  assign a_standby = stby[0];
  assign b_standby = stby[1];

  // gate acts with no clock between pin and enable
  assign a_dq_oe_n = lane_off[0] | {2{a_output_gate_n}};
  assign b_dq_oe_n = lane_off[1] | {2{b_output_gate_n}};

  // shared storage
  logic [WORD_W-1:0] mem [DEPTH];

  // port state: registers, plus idx, wr_up and wr_lo decoded from them
  logic [ADDR_W-1:0] addr_q  [PORTS];
  logic [ADDR_W-1:0] idx     [PORTS];
  logic [WORD_W-1:0] data_q  [PORTS];
  logic [WORD_W-1:0] read_q  [PORTS];
  logic              rd_q    [PORTS];
  logic              rd_q2   [PORTS];
  logic              ub_q    [PORTS];
  logic              lb_q    [PORTS];
  logic              sel1    [PORTS];
  logic              sel2    [PORTS];
  logic              lat_s1  [PORTS];
  logic              pipe    [PORTS];
  logic              wr_up   [PORTS];
  logic              wr_lo   [PORTS];

  // one write path per lane per port; port b wins a same-word, same-lane collision
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < PORTS; p++) begin
      if (wr_up[p]) begin
        mem[idx[p]][WORD_W-1:LANE_SPLIT] <=
          data_q[p][WORD_W-1:LANE_SPLIT];
      end
      if (wr_lo[p]) begin
        mem[idx[p]][LANE_SPLIT-1:0] <= data_q[p][LANE_SPLIT-1:0];
      end
    end
  end

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    address_counter #(
      .ADDR_W (ADDR_W)
    ) u_counter (
      .sys_clk               (sys_clk),
      .sys_rst               (sys_rst),
      .ext_addr              (ext_addr[p]),
      .address_load_strobe_n (load_n[p]),
      .counter_advance_n     (adv_n[p]),
      .counter_clear_n       (clr_n[p]),
      .addr                  (addr_q[p])
    );

    assign idx[p] = word_index(addr_q[p]);

    // write strobes straight from the captured controls, no wait states
    assign wr_up[p] = sel1[p] && !rd_q[p] && !ub_q[p];
    assign wr_lo[p] = sel1[p] && !rd_q[p] && !lb_q[p];

    // latency pin is asynchronous; two flops before use
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        lat_s1[p] <= 1'b0;
        pipe[p]   <= 1'b0;
      end else begin
        lat_s1[p] <= lat_pin[p];
        pipe[p]   <= lat_s1[p];
      end
    end

    // input capture
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        data_q[p] <= '0;
        rd_q[p]   <= 1'b1;
        ub_q[p]   <= 1'b1;
        lb_q[p]   <= 1'b1;
        sel1[p]   <= SEL_OFF;
      end else begin
        data_q[p] <= din[p];
        rd_q[p]   <= rd[p];
        ub_q[p]   <= ub_n[p];
        lb_q[p]   <= lb_n[p];
        sel1[p]   <= (!cs_n[p] && cs_hi[p]) ? SEL_ON : SEL_OFF;
      end
    end

    // second chip-select stage, only used when pipelined
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        sel2[p]  <= SEL_OFF;
        rd_q2[p] <= 1'b1;
      end else begin
        sel2[p]  <= sel1[p];
        rd_q2[p] <= rd_q[p];
      end
    end

    // data path; pipelined adds exactly one register
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        read_q[p] <= '0;
        dout[p]   <= '0;
      end else begin
        read_q[p] <= mem[idx[p]];
        dout[p]   <= pipe[p] ? read_q[p] : mem[idx[p]];
      end
    end

    // lane drive: byte selects stay single staged even when pipelined
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        lane_off[p] <= LANES_OFF;
        stby[p]     <= 1'b1;
      end else begin
        if (pipe[p]) begin
          lane_off[p][UPPER] <= !(sel2[p] && rd_q2[p] && !ub_q[p]);
          lane_off[p][LOWER] <= !(sel2[p] && rd_q2[p] && !lb_q[p]);
          stby[p]            <= !sel2[p];
        end else begin
          lane_off[p][UPPER] <= !(sel1[p] && rd_q[p] && !ub_q[p]);
          lane_off[p][LOWER] <= !(sel1[p] && rd_q[p] && !lb_q[p]);
          stby[p]            <= !sel1[p];
        end
      end
    end

    a_addr_load: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (!load_n[p] && clr_n[p]) |=> (addr_q[p] == $past(ext_addr[p])))
      else $error("external address not loaded");

    a_clear_wins: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !clr_n[p] |=> (addr_q[p] == '0))
      else $error("clear did not zero the address");

    a_count_step: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (load_n[p] && clr_n[p] && !adv_n[p])
        |=> (addr_q[p] == ADDR_W'($past(addr_q[p]) + 1)))
      else $error("counter did not advance by one");

    a_count_hold: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (load_n[p] && clr_n[p] && adv_n[p]) |=> $stable(addr_q[p]))
      else $error("held address changed");

    a_desel_flow: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (!pipe[p] && $stable(pipe[p]) && (cs_n[p] || !cs_hi[p]))
        |=> !pipe[p] |-> ##1 (lane_off[p] == LANES_OFF && stby[p]))
      else $error("flow-through deselect not after one stage");

    a_desel_pipe: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (pipe[p] && (cs_n[p] || !cs_hi[p])) ##1 pipe[p] ##1 pipe[p]
        |=> (lane_off[p] == LANES_OFF && stby[p]))
      else $error("pipelined deselect not after two stages");

    a_byte_stage: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      ub_n[p] |=> ##1 lane_off[p][UPPER])
      else $error("upper byte select not single staged");

    a_lower_stage: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      lb_n[p] |=> ##1 lane_off[p][LOWER])
      else $error("lower byte select not single staged");

    // watches the pin itself; the gate has no register in its path
    a_gate_float: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      ((p == 0) ? a_dq_oe_n : b_dq_oe_n)
        == (gate_n[p] ? LANES_OFF : lane_off[p]))
      else $error("gate did not float both lanes");

    a_desel_nowrite: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (cs_n[p] || !cs_hi[p]) |=> !(wr_up[p] || wr_lo[p]))
      else $error("deselected port wrote memory");

    a_read_nowrite: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      rd[p] |=> !(wr_up[p] || wr_lo[p]))
      else $error("read cycle wrote memory");

    a_select_flow: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (!pipe[p] && $stable(pipe[p]) && !cs_n[p] && cs_hi[p])
        |=> !pipe[p] |-> ##1 !stby[p])
      else $error("flow-through select not after one stage");

    // port b is written last, so a loses a same-word, same-lane collision
    a_upper_write: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (wr_up[p] && (p == 1 || !wr_up[1] || idx[1] != idx[0]))
        |=> (mem[$past(idx[p])][WORD_W-1:LANE_SPLIT]
          == $past(data_q[p][WORD_W-1:LANE_SPLIT])))
      else $error("upper lane write lost");

    a_lower_write: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (wr_lo[p] && (p == 1 || !wr_lo[1] || idx[1] != idx[0]))
        |=> (mem[$past(idx[p])][LANE_SPLIT-1:0]
          == $past(data_q[p][LANE_SPLIT-1:0])))
      else $error("lower lane write lost");

    // mode pin lands two edges late, so traffic must not rely on it sooner
    a_sync_depth: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !$past(sys_rst, 2) |-> (pipe[p] == $past(lat_pin[p], 2)))
      else $error("latency select not two flops deep");

    a_pipe_delay: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (pipe[p] && $stable(pipe[p])) |=> pipe[p] |->
        (dout[p] == $past(read_q[p])))
      else $error("pipelined data not one cycle later");
  end

  a_write_both: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (wr_up[1] && wr_lo[1]) |=> (mem[$past(idx[1])] == $past(data_q[1])))
    else $error("write did not store both lanes");
endmodule

// >>> bench/host_port.sv
// host model that drives port b, loading a fresh address for each command
`timescale 1ns/1ps
module host_port
  import ram_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  go,
  input  wire logic                  wr,
  input  wire logic [ADDR_WIDTH-1:0] ad,
  input  wire logic [WORD_W-1:0]     wd,
  output logic      [ADDR_WIDTH-1:0] addr,
  output logic                       ld_n,
  output logic      [1:0]            cnt_n,
  output logic                       cs_n,
  output logic                       cs_hi,
  output logic      [1:0]            bs_n,
  output logic                       rd,
  output logic                       gate_n,
  output logic                       lat,
  output logic      [WORD_W-1:0]     dq
);
  // latency is chosen once and never changed under traffic
  assign lat    = 1'b0;
  assign gate_n = 1'b0;
  assign cs_hi  = 1'b1;
  assign bs_n   = 2'h0;
  // never advances, so no counter start value is relied on
  assign cnt_n  = 2'h3;
  initial begin
    {addr, ld_n, cs_n, rd, dq} = '1;
  end
  always @(posedge sys_clk) begin
    ld_n <= ~go;
    cs_n <= ~go;
    if (go) begin
      addr <= ad;
      rd   <= ~wr;
      dq   <= wd;
    end else begin
      // released bus must not keep the last word
      dq <= ~dq;
    end
  end
endmodule

// >>> bench/dual_port_ram_tb_top.sv
// self-checking bench: port a driven here, port b by the host model
`timescale 1ns/1ps
module dual_port_ram_tb_top;
  import ram_pkg::*;
  localparam logic [3:0] LOAD = 4'h5, ADV = 4'h6, HOLD = 4'h7, CLR = 4'h0;
  logic                  sys_clk, sys_rst, a_cs_n, a_cl_n, a_ld_n, a_av_n;
  logic                  a_cs_hi, a_rd, a_gate_n, a_lat, b_go, b_wr, a_sb;
  logic [1:0]            a_bs, a_oe_n, b_oe_n, bs, p_cnt, p_bs;
  logic [ADDR_WIDTH-1:0] a_ad, b_ad, x, p_ad;
  logic [WORD_W-1:0]     a_d, b_wd, w, a_q, b_q, p_d;
  logic [WORD_W-1:0]     mem [2**ADDR_WIDTH];
  logic [ADDR_WIDTH-1:0] list [16];
  logic                  p_ld, p_cs, p_ch, p_rd, p_g, p_l, b_sb;
  int                    errors, n_checks, seed;

  host_port i_host (.sys_clk(sys_clk), .go(b_go), .wr(b_wr), .ad(b_ad),
    .wd(b_wd), .addr(p_ad), .ld_n(p_ld), .cnt_n(p_cnt), .cs_n(p_cs),
    .cs_hi(p_ch), .bs_n(p_bs), .rd(p_rd), .gate_n(p_g), .lat(p_l),
    .dq(p_d));

  dual_port_ram i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .a_addr(a_ad), .a_address_load_strobe_n(a_ld_n),
    .a_counter_advance_n(a_av_n), .a_counter_clear_n(a_cl_n),
    .a_chip_select_n(a_cs_n), .a_chip_select_active_high(a_cs_hi),
    .a_upper_byte_select_n(a_bs[1]), .a_lower_byte_select_n(a_bs[0]),
    .a_read_not_write(a_rd), .a_output_gate_n(a_gate_n),
    .a_output_latency_select(a_lat), .a_dq_in(a_d), .a_dq_out(a_q),
    .a_dq_oe_n(a_oe_n), .a_standby(a_sb),
    .b_addr(p_ad), .b_address_load_strobe_n(p_ld),
    .b_counter_advance_n(p_cnt[1]), .b_counter_clear_n(p_cnt[0]),
    .b_chip_select_n(p_cs), .b_chip_select_active_high(p_ch),
    .b_upper_byte_select_n(p_bs[1]), .b_lower_byte_select_n(p_bs[0]),
    .b_read_not_write(p_rd), .b_output_gate_n(p_g),
    .b_output_latency_select(p_l), .b_dq_in(p_d), .b_dq_out(b_q),
    .b_dq_oe_n(b_oe_n), .b_standby(b_sb));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] e);
    n_checks++;
    if (got !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, e);
    end
  endtask

  // ctl is {chip_select_n, clear_n, load_n, advance_n}
  task automatic drive(input logic [3:0] ctl, input logic r,
                       input logic [ADDR_WIDTH-1:0] ad,
                       input logic [WORD_W-1:0] d, input logic [1:0] s);
    @(posedge sys_clk);
    {a_cs_n, a_cl_n, a_ld_n, a_av_n} <= ctl;
    {a_rd, a_ad, a_d, a_bs} <= {r, ad, d, s};
  endtask

  task automatic after(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  initial begin
    repeat (2000) @(posedge sys_clk);
    errors++;
    test_done();
  end

  initial begin
    {errors, n_checks, seed} = {32'h0, 32'h0, 32'h650A9021};
    {sys_rst, a_cs_n, a_cl_n, a_ld_n, a_av_n, a_cs_hi, a_rd} = 7'h4F;
    {a_gate_n, a_lat, a_bs, a_ad, a_d} = '0;
    {b_go, b_wr, b_ad, b_wd} = '0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // both ports write back to back, each in its own half
    for (int i = 0; i < 8; i++) begin
      list[i] = {1'b0, 3'(i), 9'($random(seed))};
      list[i+8] = list[i] | 13'h1000;
      w = WORD_W'($random(seed));
      mem[list[i]] = w;
      drive(LOAD, 1'b0, list[i], w, LANES_ON);
      w = WORD_W'($random(seed));
      mem[list[i+8]] = w;
      {b_go, b_wr, b_ad, b_wd} <= {2'h3, list[i+8], w};
    end
    for (int i = 0; i < 18; i++) begin
      drive(LOAD, 1'b1, list[i%16], '0, LANES_ON);
      if (i == 0) b_go <= 1'b0;
      #1;
      if (i >= 2) begin
        chk(a_q, mem[list[i-2]]);
        chk(WORD_W'(a_oe_n), WORD_W'(LANES_ON));
      end
    end
    @(posedge sys_clk);
    {b_go, b_wr, b_ad} <= {2'h2, list[0]};
    after(3);
    chk(b_q, mem[list[0]]);
    chk(WORD_W'({b_sb, b_oe_n}), WORD_W'({SEL_OFF, LANES_ON}));
    b_go <= 1'b0;
    after(3);
    chk(WORD_W'({b_sb, b_oe_n}), WORD_W'({SEL_ON, LANES_OFF}));
    // each byte-select pattern with at least one lane high, on write and on read
    x = list[1];
    for (int k = 1; k < 4; k++) begin
      w = WORD_W'($random(seed));
      bs = 2'(k);
      if (!bs[UPPER]) mem[x][17:LANE_SPLIT] = w[17:LANE_SPLIT];
      if (!bs[LOWER]) mem[x][LANE_SPLIT-1:0] = w[LANE_SPLIT-1:0];
      drive(LOAD, 1'b0, x, w, bs);
      drive(LOAD, 1'b1, x, '0, bs);
      after(2);
      chk(WORD_W'(a_oe_n), WORD_W'(bs));
      drive(LOAD, 1'b1, x, '0, LANES_ON);
      after(2);
      chk(a_q, mem[x]);
    end
    for (int i = 0; i < 4; i++) begin
      mem[i] = WORD_W'($random(seed));
      drive(LOAD, 1'b0, 13'(i), mem[i], LANES_ON);
    end
    drive(CLR, 1'b1, list[2], '0, LANES_ON);
    after(2);
    chk(a_q, mem[0]);
    drive(4'hE, 1'b1, list[2], '0, LANES_ON);
    drive(HOLD, 1'b1, list[2], '0, LANES_ON);
    after(2);
    chk(a_q, mem[1]);
    drive(ADV, 1'b1, list[2], '0, LANES_ON);
    after(2);
    chk(a_q, mem[2]);
    // gate floats the lanes with no clock edge in between
    @(posedge sys_clk);
    a_gate_n <= 1'b1;
    #1;
    chk(WORD_W'(a_oe_n), WORD_W'(LANES_OFF));
    drive(HOLD, 1'b1, 13'h0, '0, LANES_ON);
    a_gate_n <= 1'b0;
    a_cs_hi <= 1'b0;
    after(1);
    chk(WORD_W'(a_sb), WORD_W'(SEL_OFF));
    after(1);
    chk(WORD_W'({a_sb, a_oe_n}), WORD_W'({SEL_ON, LANES_OFF}));
    drive(LOAD, 1'b1, 13'h0, '0, LANES_ON);
    a_cs_hi <= 1'b1;
    a_lat <= 1'b1;
    after(5);
    drive(LOAD, 1'b1, 13'h1, '0, LANES_ON);
    after(2);
    chk(a_q, mem[0]);
    after(1);
    chk(a_q, mem[1]);
    drive(4'hD, 1'b1, 13'h1, '0, LANES_ON);
    after(2);
    chk(WORD_W'(a_sb), WORD_W'(SEL_OFF));
    after(1);
    chk(WORD_W'(a_sb), WORD_W'(SEL_ON));
    test_done();
  end
endmodule
